// ### ccr_pkg.sv
// Purpose: constants for the command control register block
// Assumes: 32-bit AXI4-Lite register bus, 125 MHz clock
// Notes: offsets and pointer registers placed by this block
package ccr_pkg;
    localparam int CCR_ADDR_W = 4;
    localparam logic [3:0] CCR_OFF_CMD = 4'h0;     // command control word
    localparam logic [3:0] CCR_OFF_CAMPTR = 4'h4;  // table descriptor pointer
    localparam logic [3:0] CCR_OFF_RRP = 4'h8;     // resource read pointer
    localparam logic [3:0] CCR_OFF_TIMER = 4'hC;   // watchdog count, read only
    localparam int CCR_BIT_CAM = 9;
    localparam int CCR_BIT_RRA = 8;
    localparam int CCR_BIT_RST = 7;
    localparam int CCR_BIT_RUN = 5;
    localparam int CCR_BIT_HALT = 4;
    localparam logic [15:0] CCR_CMD_RESET = 16'h0080;
    localparam logic [1:0] CCR_RESP_OK = 2'h0;
    localparam logic [1:0] CCR_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {CCR_IDLE, CCR_CAM, CCR_RRA} ccr_fetch_e;
endpackage

// ### ccr_command_control.sv
// Purpose: command control bits (table load, resource fetch, soft reset, watchdog)
// Assumes: descriptor engines answer each request with one done pulse
// Notes: one write and one read in flight at most on the register bus
//
// Notes on behaviour
// - setting bit 9 fetches descriptor at table pointer, loads match table.
// - setting bit 8 fetches next resource descriptor at read pointer.
// - while bit 7 set, all internal state machines stay in reset.
// - during soft reset, crc disabled and tally counters frozen, not cleared.
// - operation resumes only after software returns bit 7 to zero.
// - hardware reset sets bit 7 to one.
// - setting bit 5 starts watchdog or resumes after halt.
// - writing one to bit 5 clears the halt bit; here a write that also sets bit 4 leaves halt set.
// - setting bit 4 stops watchdog and clears run bit.
// - halted watchdog keeps its count and resumes from it.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ccr_command_control
    import ccr_pkg::*;
#(
    parameter int TIMER_W = 16
) (
    input wire logic aclk,                 // system clock
    input wire logic aresetn,              // synchronous reset, low active
    input wire logic [CCR_ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid,        // write address valid
    output logic s_axi_awready,            // write address ready
    input wire logic [31:0] s_axi_wdata,   // write data
    input wire logic [3:0] s_axi_wstrb,    // byte enables
    input wire logic s_axi_wvalid,         // write data valid
    output logic s_axi_wready,             // write data ready
    output logic [1:0] s_axi_bresp,        // write response
    output logic s_axi_bvalid,             // write response valid
    input wire logic s_axi_bready,         // write response ready
    input wire logic [CCR_ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid,        // read address valid
    output logic s_axi_arready,            // read address ready
    output logic [31:0] s_axi_rdata,       // read data
    output logic [1:0] s_axi_rresp,        // read response
    output logic s_axi_rvalid,             // read data valid
    input wire logic s_axi_rready,         // read data ready
    output logic cam_fetch_req,            // table descriptor fetch request
    output logic [31:0] cam_fetch_addr,    // table descriptor address
    input wire logic cam_fetch_done,       // table load finished pulse
    output logic rra_fetch_req,            // resource descriptor fetch request
    output logic [31:0] rra_fetch_addr,    // resource descriptor address
    input wire logic rra_fetch_done,       // resource fetch finished pulse
    output logic sm_reset,                 // hold internal machines in reset
    output logic crc_enable,               // crc generator enable
    output logic tally_enable,             // tally counters count when high
    output logic [TIMER_W-1:0] timer_count // watchdog count
);
    logic [15:0] cmd_r;
    logic [31:0] camptr_r, rrp_r;
    logic [TIMER_W-1:0] timer_r;
    ccr_fetch_e fetch_r, fetch_nxt;
    logic aw_got_r, w_got_r;
    logic [CCR_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [31:0] rdata_nxt;
    logic rd_hit;

    // write channel capture; address and data may arrive in any order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    wire wr_hit = (awaddr_r == CCR_OFF_CMD) || (awaddr_r == CCR_OFF_CAMPTR)
        || (awaddr_r == CCR_OFF_RRP) || (awaddr_r == CCR_OFF_TIMER);
    wire wr_cmd = wr_fire && awaddr_r == CCR_OFF_CMD && wstrb_r[1:0] == 2'h3;
    wire wr_cam = wr_fire && awaddr_r == CCR_OFF_CAMPTR;
    wire wr_rrp = wr_fire && awaddr_r == CCR_OFF_RRP;
    wire rd_take = s_axi_arvalid && s_axi_arready;

    // command bit decode of a whole-halfword write
    wire set_cam = wr_cmd && wdata_r[CCR_BIT_CAM];
    wire set_rra = wr_cmd && wdata_r[CCR_BIT_RRA];
    wire set_run = wr_cmd && wdata_r[CCR_BIT_RUN];
    wire set_halt = wr_cmd && wdata_r[CCR_BIT_HALT];
    wire soft_rst = cmd_r[CCR_BIT_RST];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CCR_RESP_OK;
        end else begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? CCR_RESP_OK : CCR_RESP_SLVERR;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // command word; halt beats run, and a fetch set written as that fetch ends beats its self-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_r <= CCR_CMD_RESET;
        end else begin
            if (wr_cmd) begin
                cmd_r[CCR_BIT_RST] <= wdata_r[CCR_BIT_RST];
            end
            if (set_cam) begin
                cmd_r[CCR_BIT_CAM] <= 1'b1;
            end else if (fetch_r == CCR_CAM && (cam_fetch_done || soft_rst)) begin
                cmd_r[CCR_BIT_CAM] <= 1'b0;
            end
            if (set_rra) begin
                cmd_r[CCR_BIT_RRA] <= 1'b1;
            end else if (fetch_r == CCR_RRA && (rra_fetch_done || soft_rst)) begin
                cmd_r[CCR_BIT_RRA] <= 1'b0;
            end
            if (set_halt) begin
                cmd_r[CCR_BIT_HALT] <= 1'b1;
                cmd_r[CCR_BIT_RUN] <= 1'b0;
            end else if (set_run) begin
                cmd_r[CCR_BIT_RUN] <= 1'b1;
                cmd_r[CCR_BIT_HALT] <= 1'b0;
            end
        end
    end

    // pointer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            camptr_r <= '0;
            rrp_r <= '0;
        end else begin
            if (wr_cam) begin
                camptr_r <= wdata_r;
            end
            if (wr_rrp) begin
                rrp_r <= wdata_r;
            end
        end
    end

    // fetch sequencer; table load served before resource fetch
    always_comb begin
        fetch_nxt = fetch_r;
        case (fetch_r)
            CCR_IDLE: begin
                if (cmd_r[CCR_BIT_CAM]) begin
                    fetch_nxt = CCR_CAM;
                end else if (cmd_r[CCR_BIT_RRA]) begin
                    fetch_nxt = CCR_RRA;
                end
            end
            CCR_CAM: begin
                if (cam_fetch_done) begin
                    fetch_nxt = CCR_IDLE;
                end
            end
            CCR_RRA: begin
                if (rra_fetch_done) begin
                    fetch_nxt = CCR_IDLE;
                end
            end
            default: fetch_nxt = CCR_IDLE;
        endcase
    end

    // soft reset holds the sequencer idle and blocks new fetches
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_rst) begin
            fetch_r <= CCR_IDLE;
            cam_fetch_req <= 1'b0;
            rra_fetch_req <= 1'b0;
            cam_fetch_addr <= '0;
            rra_fetch_addr <= '0;
        end else begin
            fetch_r <= fetch_nxt;
            cam_fetch_req <= fetch_nxt == CCR_CAM;
            rra_fetch_req <= fetch_nxt == CCR_RRA;
            cam_fetch_addr <= camptr_r;
            rra_fetch_addr <= rrp_r;
        end
    end

    // watchdog counts only while run set; halt keeps the count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_r <= '0;
        end else if (cmd_r[CCR_BIT_RUN] && !soft_rst) begin
            timer_r <= timer_r + 1'b1;
        end
    end

    // status outputs registered so they come straight from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sm_reset <= 1'b1;
            crc_enable <= 1'b0;
            tally_enable <= 1'b0;
            timer_count <= '0;
        end else begin
            sm_reset <= soft_rst;
            crc_enable <= !soft_rst;
            tally_enable <= !soft_rst;
            timer_count <= timer_r;
        end
    end

    // read decode
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            CCR_OFF_CMD: rdata_nxt = {16'h0000, cmd_r};
            CCR_OFF_CAMPTR: rdata_nxt = camptr_r;
            CCR_OFF_RRP: rdata_nxt = rrp_r;
            CCR_OFF_TIMER: rdata_nxt = 32'(timer_r);
            default: begin
                rdata_nxt = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= CCR_RESP_OK;
        end else if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_nxt;
            s_axi_rresp <= rd_hit ? CCR_RESP_OK : CCR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### ccr_command_control_asserts.sv
// Purpose: port-level checks of the command control block
// Assumes: single clock, synchronous low-active reset
// Notes: bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
module ccr_command_control_asserts #(parameter int TIMER_W = 16) (
    input wire logic aclk,                  // clock
    input wire logic aresetn,               // reset, low active
    input wire logic cam_fetch_req,         // table fetch request
    input wire logic cam_fetch_done,        // table fetch done
    input wire logic rra_fetch_req,         // resource fetch request
    input wire logic rra_fetch_done,        // resource fetch done
    input wire logic sm_reset,              // machines held in reset
    input wire logic crc_enable,            // crc enable
    input wire logic tally_enable,          // tally enable
    input wire logic [TIMER_W-1:0] timer_count // watchdog count
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_fetch_held_idle: assert property (sm_reset [*2] |-> !cam_fetch_req && !rra_fetch_req)
        else $error("fetch request while soft reset holds");
    a_crc_tally_off: assert property (crc_enable == !sm_reset && tally_enable == !sm_reset)
        else $error("crc or tally enable disagrees with soft reset");
    a_timer_frozen: assert property (sm_reset [*3] |-> $stable(timer_count))
        else $error("watchdog moved during soft reset");
    a_cam_self_clear: assert property (cam_fetch_req && cam_fetch_done |=> !cam_fetch_req)
        else $error("table request stayed after done");
    a_rra_self_clear: assert property (rra_fetch_req && rra_fetch_done |=> !rra_fetch_req)
        else $error("resource request stayed after done");
    a_one_fetch: assert property (cam_fetch_req |-> !rra_fetch_req)
        else $error("both fetches requested at once");
    a_boot_soft_reset: assert property ($rose(aresetn) |-> sm_reset ##1 sm_reset)
        else $error("soft reset not set by hardware reset");
    a_timer_step: assert property ($changed(timer_count) |-> timer_count == $past(timer_count) + 1'b1)
        else $error("watchdog jumped");
endmodule
bind ccr_command_control ccr_command_control_asserts #(.TIMER_W(TIMER_W)) ccr_command_control_asserts_inst (
    .aclk(aclk), .aresetn(aresetn), .cam_fetch_req(cam_fetch_req),
    .cam_fetch_done(cam_fetch_done), .rra_fetch_req(rra_fetch_req),
    .rra_fetch_done(rra_fetch_done), .sm_reset(sm_reset), .crc_enable(crc_enable),
    .tally_enable(tally_enable), .timer_count(timer_count));
`default_nettype wire

// ### ccr_fetch_model.sv
// Purpose: descriptor engines answering table and resource fetches
// Assumes: one request high at a time
// Notes: answer delay set by the bench, zero gives a prompt answer
`timescale 1ns/100ps
`default_nettype none
module ccr_fetch_model (
    input wire logic aclk,                   // clock
    input wire logic aresetn,                // reset, low active
    input wire logic [3:0] delay,            // cycles before done
    input wire logic cam_fetch_req,          // table request
    input wire logic [31:0] cam_fetch_addr,  // table address
    output logic cam_fetch_done,             // table done pulse
    input wire logic rra_fetch_req,          // resource request
    input wire logic [31:0] rra_fetch_addr,  // resource address
    output logic rra_fetch_done,             // resource done pulse
    output logic [31:0] cam_seen,            // last table address served
    output logic [31:0] rra_seen             // last resource address served
);
    logic [3:0] cnt_r;
    // one pulse per request; the counter restarts after a pulse so no double answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 4'h0;
            cam_fetch_done <= 1'b0;
            rra_fetch_done <= 1'b0;
            cam_seen <= 32'h0;
            rra_seen <= 32'h0;
        end else begin
            cam_fetch_done <= 1'b0;
            rra_fetch_done <= 1'b0;
            if (!(cam_fetch_req || rra_fetch_req) || cam_fetch_done || rra_fetch_done) begin
                cnt_r <= 4'h0;
            end else if (cnt_r == delay) begin
                cam_fetch_done <= cam_fetch_req;
                rra_fetch_done <= rra_fetch_req;
                if (cam_fetch_req) cam_seen <= cam_fetch_addr;
                if (rra_fetch_req) rra_seen <= rra_fetch_addr;
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### ccr_tb.sv
// Purpose: self-checking bench of the command control block
// Assumes: register bus answers within 50 cycles
// Notes: software never sets the table load with transmit pending
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ccr_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bvalid, bready = 1'b0;
    logic arvalid = 1'b0, rvalid, rready = 1'b0, awready, wready, arready;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, dly = 4'h3;
    logic [31:0] wdata = 32'h0, rdata, cam_addr, rra_addr, cam_seen, rra_seen, t1, t2;
    logic cam_req, cam_done, rra_req, rra_done, sm_reset, crc_en, tally_en;
    logic [15:0] tcount;
    logic [1:0] bresp, rresp, resp_w, resp_r;
    logic [3:0] wstrb = 4'hF;
    int miscompares = 0, checks_done = 0;
    always #4 aclk = ~aclk;
    ccr_command_control ccr_command_control_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cam_fetch_req(cam_req),
        .cam_fetch_addr(cam_addr), .cam_fetch_done(cam_done), .rra_fetch_req(rra_req),
        .rra_fetch_addr(rra_addr), .rra_fetch_done(rra_done), .sm_reset(sm_reset),
        .crc_enable(crc_en), .tally_enable(tally_en), .timer_count(tcount));
    ccr_fetch_model ccr_fetch_model_inst (.aclk(aclk), .aresetn(aresetn), .delay(dly),
        .cam_fetch_req(cam_req), .cam_fetch_addr(cam_addr), .cam_fetch_done(cam_done),
        .rra_fetch_req(rra_req), .rra_fetch_addr(rra_addr), .rra_fetch_done(rra_done),
        .cam_seen(cam_seen), .rra_seen(rra_seen));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        resp_w = bresp;
        bready <= 1'b0;
        if (n == 50) begin miscompares++; final_report(); end
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int n;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata; rready <= 1'b0;
        resp_r = rresp;
        if (n == 50) begin miscompares++; final_report(); end
        @(posedge aclk);
    endtask
    task automatic t_boot();
        rd(CCR_OFF_CMD, t1); chk("cmd", 32'h80, t1);
        chk("en_sm", 32'h1, 32'({crc_en, tally_en, sm_reset}));
        $display("boot test ended");
    endtask
    // refused writes: single-byte strobe on the command word is dropped, unmapped word answers error
    task automatic t_refuse();
        wstrb <= 4'h1;
        wr(CCR_OFF_CMD, 32'h0);
        wstrb <= 4'hF;
        chk("bresp_ok", 32'(CCR_RESP_OK), 32'(resp_w));
        rd(CCR_OFF_CMD, t1); chk("strobe_ignored", 32'h80, t1);
        chk("rresp_ok", 32'(CCR_RESP_OK), 32'(resp_r));
        wr(4'h2, 32'h0); chk("bresp_err", 32'(CCR_RESP_SLVERR), 32'(resp_w));
        rd(4'h2, t1); chk("rresp_err", 32'(CCR_RESP_SLVERR), 32'(resp_r));
        chk("rd_zero", 32'h0, t1);
        $display("refuse test ended");
    endtask
    // load is requested during soft reset, must wait pending, then run once released
    task automatic t_fetch(input logic [31:0] pa, input logic [31:0] pb, input logic [3:0] d);
        int n;
        dly <= d;
        wr(CCR_OFF_CAMPTR, pa); wr(CCR_OFF_RRP, pb);
        wr(CCR_OFF_CMD, 32'h380);
        repeat (5) @(posedge aclk);
        chk("req_held", 32'h0, {cam_req, rra_req});
        rd(CCR_OFF_CMD, t1); chk("pending", 32'h380, t1);
        wr(CCR_OFF_CMD, 32'h300);
        for (n = 0; n < 20 && t1[9:8] != 2'b00; n++) rd(CCR_OFF_CMD, t1);
        chk("cmd_clear", 32'h0, t1);
        chk("cam_addr", pa, cam_seen);
        chk("rra_addr", pb, rra_seen);
        wr(CCR_OFF_CMD, 32'h80);
        $display("fetch test ended");
    endtask
    task automatic t_timer();
        wr(CCR_OFF_CMD, 32'h20); repeat (10) @(posedge aclk);
        wr(CCR_OFF_CMD, 32'h30); rd(CCR_OFF_CMD, t1); chk("halt", 32'h10, t1);
        rd(CCR_OFF_TIMER, t1); repeat (10) @(posedge aclk); rd(CCR_OFF_TIMER, t2);
        chk("kept", t1, t2);
        chk("counted", 32'h1, {31'h0, t1 != 0});
        wr(CCR_OFF_CMD, 32'h20); rd(CCR_OFF_CMD, t1); chk("run", 32'h20, t1);
        rd(CCR_OFF_TIMER, t1); chk("resumed", 32'h1, {31'h0, t1 > t2});
        wr(CCR_OFF_CMD, 32'hA0); repeat (2) @(posedge aclk);
        chk("soft_en", 32'h1, 32'({crc_en, tally_en, sm_reset}));
        rd(CCR_OFF_TIMER, t1); repeat (8) @(posedge aclk); rd(CCR_OFF_TIMER, t2);
        chk("frozen", t1, t2);
        wr(CCR_OFF_CMD, 32'h20); repeat (2) @(posedge aclk);
        chk("resume_en", 32'h6, 32'({crc_en, tally_en, sm_reset}));
        $display("timer test ended");
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_boot();
        t_refuse();
        t_fetch(32'h1230, 32'h4560, 4'h3);
        t_fetch(32'hA5A0, 32'h5A50, 4'h0);
        t_timer();
        final_report();
    end
endmodule
`default_nettype wire
